// ### rtl/msp_sensor_port.sv
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "msp_defines.svh"
// Behaviour
// RQ1 - Port is slave only, never initiates
// RQ2 - Deselected: ignore inputs, data-out released
// RQ3 - Select rise aborts and resets port
// RQ4 - Host keeps spacing after abort
// RQ5 - Host frames each transaction with select
// RQ6 - Select rise ends burst mode
// RQ7 - Write: address with MSB 1, data
// RQ8 - Data-in sampled on clock rise
// RQ9 - Read: address MSB 0, data returned
// RQ10 - Data-out changes on clock fall
// RQ11 - Data-out held until next fall
// RQ12 - Host respects write-to-write gap
// RQ13 - Host respects write-to-read gap
// RQ14 - Host pauses clock before read data
// RQ15 - Host waits after read before next
// RQ16 - Motion pin level/edge, polarity configurable
// RQ17 - Level mode follows pending flag
// RQ18 - Edge mode: one 230us pulse from rest
// RQ19 - Flag set only with valid displacement
// RQ20 - Auto downshift run to rest three
// RQ21 - Downshift times programmable
// RQ22 - Auto LED picks current by brightness
// RQ23 - Write gap at least 30 us
// RQ24 - Write-to-read gap at least 20 us
// RQ25 - Address-to-data at least 4 us
// RQ26 - Post-read gap at least 250 ns
// RQ27 - Bytes shift MSB first
module msp_sensor_port
  import msp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        port_select_n,
  input  wire logic        sclk_in,
  input  wire logic        mosi_in,
  output logic             miso_o,
  output logic             miso_oe,
  input  wire logic        motion_seen,
  input  wire logic [7:0]  motion_dx,
  input  wire logic [7:0]  motion_dy,
  input  wire logic        surface_bright,
  output logic             motion_pin,
  output logic             led_high_current,
  output logic [3:0]       power_mode
);
  // Sensor core supplies motion events; this block keeps the host-visible state
  msp_cmd_t   cmd;
  logic       cmd_valid;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] dx_q, dx_d, dy_q, dy_d;
  logic       pend_q, pend_d;
  logic [7:0] motcfg_q, motcfg_d, ledcfg_q, ledcfg_d;
  logic [15:0] run_ds_q, run_ds_d, r1_ds_q, r1_ds_d, r2_ds_q, r2_ds_d;
  logic [19:0] tick_q, tick_d;
  logic [15:0] idle_q, idle_d;
  msp_pwr_t   pwr_q, pwr_d;
  logic [17:0] pulse_q, pulse_d;
  logic       pin_d, led_d;
  logic [31:0] prdata_d;
  logic       pslverr_d;
  logic       apb_wr, apb_rd, ack;
  logic       hit;
  logic       rd_strobe;

  msp_serial_shift msp_serial_shift_inst
  (
    .pclk          (pclk),
    .presetn       (presetn),
    .port_select_n (port_select_n),
    .sclk_in       (sclk_in),
    .mosi_in       (mosi_in),
    .rd_data       (rd_data),
    .miso_o        (miso_o),
    .miso_oe       (miso_oe),
    .cmd_valid     (cmd_valid),
    .cmd           (cmd),
    .rd_strobe     (rd_strobe),
    .rd_addr       (rd_addr)
  ); // RQ1

  // Serial read map: 2 status, 3 dx, 4 dy, 0x41 motion config, 0x43 led config
  always_comb
  begin
    case (rd_addr)
      7'h02:   rd_data = {pend_q, 7'h00};
      7'h03:   rd_data = dx_q;
      7'h04:   rd_data = dy_q;
      7'h0E:   rd_data = run_ds_q[7:0];
      7'h10:   rd_data = r1_ds_q[7:0];
      7'h12:   rd_data = r2_ds_q[7:0];
      7'h41:   rd_data = motcfg_q;
      7'h43:   rd_data = ledcfg_q;
      default: rd_data = 8'h00;
    endcase
  end

  assign ack    = psel & penable;
  assign apb_wr = ack & pwrite;
  // Reads are decoded in the setup cycle so that prdata already stands with pready
  assign apb_rd = psel & ~penable & ~pwrite;
  assign hit    = (paddr == `MSP_OFF_CTRL) | (paddr == `MSP_OFF_STATUS) | (paddr == `MSP_OFF_DELTA)
                | (paddr == `MSP_OFF_MOTCFG) | (paddr == `MSP_OFF_RUN_DS) | (paddr == `MSP_OFF_REST1_DS)
                | (paddr == `MSP_OFF_REST2_DS) | (paddr == `MSP_OFF_LEDCFG) | (paddr == `MSP_OFF_SPIDATA);

  always_comb
  begin
    dx_d     = dx_q;
    dy_d     = dy_q;
    pend_d   = pend_q;
    motcfg_d = motcfg_q;
    ledcfg_d = ledcfg_q;
    run_ds_d = run_ds_q;
    r1_ds_d  = r1_ds_q;
    r2_ds_d  = r2_ds_q;
    prdata_d = 32'h0000_0000;
    pslverr_d = 1'b0;
    // Reading delta over APB drains it; reading both clears pending
    if (apb_rd && paddr == `MSP_OFF_DELTA)
    begin
      dx_d = 8'h00;
      dy_d = 8'h00;
      pend_d = 1'b0; // RQ17
    end
    // Serial reads drain one axis each, at the edge that launches the data byte
    if (rd_strobe && rd_addr == 7'h03)
    begin
      dx_d = 8'h00; // RQ17
    end
    if (rd_strobe && rd_addr == 7'h04)
    begin
      dy_d = 8'h00; // RQ17
    end
    if (rd_strobe && dx_d == 8'h00 && dy_d == 8'h00)
    begin
      pend_d = 1'b0; // RQ17
    end
    // Serial writes of config registers
    if (cmd_valid && cmd.wr)
    begin
      case (cmd.addr)
        7'h0E:   run_ds_d = {8'h00, cmd.data}; // RQ21
        7'h10:   r1_ds_d  = {8'h00, cmd.data};
        7'h12:   r2_ds_d  = {8'h00, cmd.data};
        7'h41:   motcfg_d = cmd.data; // RQ16
        7'h43:   ledcfg_d = cmd.data; // RQ22
        default: ;
      endcase
    end
    if (apb_wr)
    begin
      case (paddr)
        `MSP_OFF_MOTCFG:   motcfg_d = pwdata[7:0];
        `MSP_OFF_RUN_DS:   run_ds_d = pwdata[15:0];
        `MSP_OFF_REST1_DS: r1_ds_d  = pwdata[15:0];
        `MSP_OFF_REST2_DS: r2_ds_d  = pwdata[15:0];
        `MSP_OFF_LEDCFG:   ledcfg_d = pwdata[7:0];
        default:           ;
      endcase
    end
    // New motion wins over a drain in the same cycle
    if (motion_seen && (motion_dx != 8'h00 || motion_dy != 8'h00))
    begin
      dx_d = dx_d + motion_dx;
      dy_d = dy_d + motion_dy;
      pend_d = 1'b1; // RQ19
    end
    if (apb_rd)
    begin
      case (paddr)
        `MSP_OFF_CTRL:     prdata_d = {28'h000_0000, pwr_q};
        `MSP_OFF_STATUS:   prdata_d = {30'h0000_0000, motion_pin, pend_q};
        `MSP_OFF_DELTA:    prdata_d = {16'h0000, dy_q, dx_q};
        `MSP_OFF_MOTCFG:   prdata_d = {24'h00_0000, motcfg_q};
        `MSP_OFF_RUN_DS:   prdata_d = {16'h0000, run_ds_q};
        `MSP_OFF_REST1_DS: prdata_d = {16'h0000, r1_ds_q};
        `MSP_OFF_REST2_DS: prdata_d = {16'h0000, r2_ds_q};
        `MSP_OFF_LEDCFG:   prdata_d = {24'h00_0000, ledcfg_q};
        `MSP_OFF_SPIDATA:  prdata_d = {16'h0000, cmd};
        default:           prdata_d = 32'h0000_0000;
      endcase
    end
    if (psel && !penable && !hit)
    begin
      pslverr_d = 1'b1;
    end
  end

  // Power state: idle time counted in ticks of one millisecond
  always_comb
  begin
    tick_d = (tick_q == `MSP_TICK_CYC - 20'd1) ? 20'd0 : tick_q + 20'd1;
    idle_d = idle_q;
    pwr_d  = pwr_q;
    if (motion_seen)
    begin
      idle_d = 16'h0000;
      pwr_d  = MSP_RUN;
    end
    else if (tick_q == `MSP_TICK_CYC - 20'd1)
    begin
      idle_d = idle_q + 16'h0001;
      case (pwr_q)
        MSP_RUN:
        begin
          if (idle_q >= run_ds_q)
          begin
            pwr_d = MSP_REST1; // RQ20
            idle_d = 16'h0000;
          end
        end
        MSP_REST1:
        begin
          if (idle_q >= r1_ds_q)
          begin
            pwr_d = MSP_REST2;
            idle_d = 16'h0000;
          end
        end
        MSP_REST2:
        begin
          if (idle_q >= r2_ds_q)
          begin
            pwr_d = MSP_REST3;
            idle_d = 16'h0000;
          end
        end
        MSP_REST3: idle_d = idle_q;
        default:   pwr_d = MSP_RUN;
      endcase
    end
  end

  // Motion pin: edge pulse only for wake from a rest mode
  always_comb
  begin
    pulse_d = (pulse_q != 18'd0) ? pulse_q - 18'd1 : 18'd0;
    if (motion_seen && pwr_q != MSP_RUN)
    begin
      pulse_d = 18'(`MSP_PULSE_CYC); // RQ18
    end
    if (motcfg_q[`MSP_MOT_EDGE_BIT])
    begin
      pin_d = (pulse_q != 18'd0);
    end
    else
    begin
      pin_d = pend_q; // RQ17
    end
    pin_d = motcfg_q[`MSP_MOT_HIGH_BIT] ? pin_d : ~pin_d; // RQ16
    led_d = ledcfg_q[`MSP_LED_AUTO_BIT] ? ~surface_bright : led_high_current; // RQ22
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dx_q     <= 8'h00;
      dy_q     <= 8'h00;
      pend_q   <= 1'b0;
      motcfg_q <= `MSP_MOTCFG_RST;
      ledcfg_q <= `MSP_LEDCFG_RST;
      run_ds_q <= `MSP_RUN_DS_RST;
      r1_ds_q  <= `MSP_REST1_DS_RST;
      r2_ds_q  <= `MSP_REST2_DS_RST;
      tick_q   <= 20'd0;
      idle_q   <= 16'h0000;
      pwr_q    <= MSP_RUN;
      pulse_q  <= 18'd0;
      motion_pin <= 1'b1;
      led_high_current <= 1'b1;
      power_mode <= 4'h1;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end
    else
    begin
      dx_q     <= dx_d;
      dy_q     <= dy_d;
      pend_q   <= pend_d;
      motcfg_q <= motcfg_d;
      ledcfg_q <= ledcfg_d;
      run_ds_q <= run_ds_d;
      r1_ds_q  <= r1_ds_d;
      r2_ds_q  <= r2_ds_d;
      tick_q   <= tick_d;
      idle_q   <= idle_d;
      pwr_q    <= pwr_d;
      pulse_q  <= pulse_d;
      motion_pin <= pin_d;
      led_high_current <= led_d;
      power_mode <= pwr_d;
      prdata   <= prdata_d;
      pready   <= psel & ~penable;
      pslverr  <= pslverr_d;
    end
  end
endmodule

// ### shared/msp_defines.svh
`ifndef MSP_DEFINES_SVH
`define MSP_DEFINES_SVH
// APB register byte offsets
`define MSP_OFF_CTRL     12'h000
`define MSP_OFF_STATUS   12'h004
`define MSP_OFF_DELTA    12'h008
`define MSP_OFF_MOTCFG   12'h00C
`define MSP_OFF_RUN_DS   12'h010
`define MSP_OFF_REST1_DS 12'h014
`define MSP_OFF_REST2_DS 12'h018
`define MSP_OFF_LEDCFG   12'h01C
`define MSP_OFF_SPIDATA  12'h020
// Motion config fields
`define MSP_MOT_EDGE_BIT 1
`define MSP_MOT_HIGH_BIT 0
// Reset values
`define MSP_MOTCFG_RST   8'h00
`define MSP_RUN_DS_RST   16'h0046
`define MSP_REST1_DS_RST 16'h004F
`define MSP_REST2_DS_RST 16'h002F
`define MSP_LEDCFG_RST   8'h08
`define MSP_LED_AUTO_BIT 3
// Timing
`define MSP_CLK_NS       5
`define MSP_PULSE_US     230
`define MSP_PULSE_CYC    ((`MSP_PULSE_US * 1000) / `MSP_CLK_NS)
`define MSP_TICK_CYC     20'd200000
`endif

// ### shared/msp_pkg.sv
package msp_pkg;
  typedef enum logic [3:0] {
    MSP_RUN   = 4'b0001,
    MSP_REST1 = 4'b0010,
    MSP_REST2 = 4'b0100,
    MSP_REST3 = 4'b1000
  } msp_pwr_t;
  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } msp_cmd_t;
endpackage

// ### rtl/msp_serial_shift.sv
`timescale 1ns/1ps
`include "msp_defines.svh"
module msp_serial_shift
  import msp_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       port_select_n,
  input  wire logic       sclk_in,
  input  wire logic       mosi_in,
  input  wire logic [7:0] rd_data,
  output logic            miso_o,
  output logic            miso_oe,
  output logic            cmd_valid,
  output msp_cmd_t        cmd,
  output logic            rd_strobe,
  output logic [6:0]      rd_addr
);
  logic [1:0] cs_s_q;
  logic [1:0] ck_s_q;
  logic [1:0] di_s_q;
  logic       ck_old_q;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] out_q, out_d;
  logic       rd_q, rd_d;
  logic       miso_d, oe_d, val_d, strb_d;
  msp_cmd_t   cmd_d;
  logic [6:0] ra_d;
  logic       active, rise, fall;

  assign active = ~cs_s_q[1];
  assign rise   = active & ck_s_q[1] & ~ck_old_q; // RQ8
  assign fall   = active & ~ck_s_q[1] & ck_old_q;

  always_comb
  begin
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    out_d  = out_q;
    rd_d   = rd_q;
    miso_d = miso_o;
    oe_d   = active; // RQ2
    val_d  = 1'b0;
    strb_d = 1'b0;
    cmd_d  = cmd;
    ra_d   = rd_addr;
    if (!active)
    begin
      cnt_d  = 4'h0; // RQ3 RQ6
      rd_d   = 1'b0;
      miso_d = 1'b0;
    end
    else
    begin
      if (rise && cnt_q < 4'd8)
      begin
        sh_d = {sh_q[6:0], di_s_q[1]}; // RQ27
        cnt_d = cnt_q + 4'd1;
        if (cnt_q == 4'd7)
        begin
          rd_d = ~sh_q[6]; // RQ9
          ra_d = {sh_q[5:0], di_s_q[1]};
        end
      end
      else if (rise && cnt_q < 4'd15)
      begin
        sh_d = {sh_q[6:0], di_s_q[1]};
        cnt_d = cnt_q + 4'd1;
      end
      else if (rise && cnt_q == 4'd15)
      begin
        cnt_d = 4'h0;
        if (!rd_q)
        begin
          val_d = 1'b1; // RQ7
          cmd_d.wr = 1'b1;
          cmd_d.addr = rd_addr;
          cmd_d.data = {sh_q[6:0], di_s_q[1]};
        end
      end
      if (fall && rd_q && cnt_q >= 4'd8)
      begin
        if (cnt_q == 4'd8)
        begin
          miso_d = rd_data[7]; // RQ10
          strb_d = 1'b1;
          out_d  = {rd_data[6:0], 1'b0};
        end
        else
        begin
          miso_d = out_q[7]; // RQ11
          out_d  = {out_q[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_s_q    <= 2'b11;
      ck_s_q    <= 2'b11;
      di_s_q    <= 2'b00;
      ck_old_q  <= 1'b1;
      cnt_q     <= 4'h0;
      sh_q      <= 8'h00;
      out_q     <= 8'h00;
      rd_q      <= 1'b0;
      miso_o    <= 1'b0;
      miso_oe   <= 1'b0;
      cmd_valid <= 1'b0;
      rd_strobe <= 1'b0;
      cmd       <= '0;
      rd_addr   <= 7'h00;
    end
    else
    begin
      cs_s_q    <= {cs_s_q[0], port_select_n};
      ck_s_q    <= {ck_s_q[0], sclk_in};
      di_s_q    <= {di_s_q[0], mosi_in};
      ck_old_q  <= ck_s_q[1];
      cnt_q     <= cnt_d;
      sh_q      <= sh_d;
      out_q     <= out_d;
      rd_q      <= rd_d;
      miso_o    <= miso_d;
      miso_oe   <= oe_d;
      cmd_valid <= val_d;
      rd_strobe <= strb_d;
      cmd       <= cmd_d;
      rd_addr   <= ra_d;
    end
  end
endmodule

// ### verif/msp_sensor_port_sva.sv
`timescale 1ns/1ps
module msp_sensor_port_sva
  import msp_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       port_select_n,
  input wire logic       sclk_in,
  input wire logic       miso_o,
  input wire logic       miso_oe,
  input wire logic [3:0] power_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("No ready in access cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("Ready outside access");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("Error without ready");
  deselect_hiz_a: assert property (port_select_n [*5] |-> !miso_oe)
    else $error("Data-out driven while deselected");
  select_drive_a: assert property (!port_select_n [*5] |-> miso_oe)
    else $error("Data-out released while selected");
  miso_hold_a: assert property ((sclk_in && !port_select_n) [*2] |-> $stable(miso_o))
    else $error("Data-out moved without clock fall");
  mode_onehot_a: assert property ($onehot(power_mode))
    else $error("Power mode not one-hot");
  mode_step_a: assert property (power_mode != $past(power_mode) && power_mode != MSP_RUN
    |-> power_mode == {$past(power_mode[2:0]), 1'b0}) else $error("Power mode skipped a level");
  cover property (pslverr);
  cover property ($rose(port_select_n));
  cover property (miso_oe && $fell(sclk_in));
endmodule

// ### verif/msp_host_model.sv
`timescale 1ns/1ps
module msp_host_model (
  output logic     port_select_n,
  output logic     sclk_in,
  output logic     mosi_in,
  input wire logic miso_o,
  input wire logic miso_oe
);
  logic last_q = 1'b0;
  logic miso_line;
  // No pull on the data-out line: a released line shows the inverse of its last value
  assign miso_line = miso_oe ? miso_o : ~last_q;
  always @(miso_o) if (miso_oe) last_q = miso_o;
  initial
  begin
    port_select_n = 1'b1;
    sclk_in = 1'b1;
    mosi_in = 1'b0;
  end
  // Host always starts the exchange; a frame is select low, 16 bits, select high
  task automatic xfer(input logic [15:0] w, output logic [7:0] r);
    #1;
    port_select_n = 1'b0;
    #200;
    for (int i = 15; i >= 0; i--)
    begin
      sclk_in = 1'b0;
      mosi_in = w[i];
      #32;
      sclk_in = 1'b1;
      #32;
      if (i < 8) r = {r[6:0], miso_line};
      if (i == 8) #4000;
    end
    #20000;
    port_select_n = 1'b1;
    #10000;
  endtask
  task automatic abort_frame();
    #1;
    port_select_n = 1'b0;
    #200;
    repeat (5)
    begin
      sclk_in = 1'b0;
      #32;
      sclk_in = 1'b1;
      #32;
    end
    port_select_n = 1'b1;
    #200;
    // Clock and data wiggle while deselected on purpose
    repeat (8)
    begin
      sclk_in = 1'b0;
      mosi_in = ~mosi_in;
      #32;
      sclk_in = 1'b1;
      #32;
    end
    #10000;
  endtask
endmodule

// ### verif/msp_sensor_port_bench.sv
`timescale 1ns/1ps
`include "msp_defines.svh"
module msp_sensor_port_bench;
  import msp_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, rerr;
  logic        port_select_n, sclk_in, mosi_in, miso_o, miso_oe;
  logic        motion_seen = 1'b0, surface_bright = 1'b0;
  logic [7:0]  motion_dx = 8'h00, motion_dy = 8'h00, sr;
  logic        motion_pin, led_high_current;
  logic [3:0]  power_mode;
  int          fails = 0, checked = 0, cycles = 0;
  msp_sensor_port msp_sensor_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_select_n(port_select_n), .sclk_in(sclk_in), .mosi_in(mosi_in), .miso_o(miso_o), .miso_oe(miso_oe),
    .motion_seen(motion_seen), .motion_dx(motion_dx), .motion_dy(motion_dy), .surface_bright(surface_bright),
    .motion_pin(motion_pin), .led_high_current(led_high_current), .power_mode(power_mode));
  msp_host_model msp_host_model_inst (.port_select_n(port_select_n), .sclk_in(sclk_in), .mosi_in(mosi_in),
    .miso_o(miso_o), .miso_oe(miso_oe));
  always #2.5 pclk = ~pclk;
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Called right after a rising edge; the answer is taken at the rising edge that sees pready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(power_mode, 32'h0000_0001);
    chk(miso_oe, 32'h0000_0000);
    chk(led_high_current, 32'h0000_0001);
    apb(1'b0, `MSP_OFF_MOTCFG, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    apb(1'b0, `MSP_OFF_LEDCFG, 32'h0000_0000);
    chk(rdat, 32'h0000_0008);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk(rerr, 32'h0000_0001);
    surface_bright <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(led_high_current, 32'h0000_0000);
    msp_host_model_inst.xfer(16'h8E21, sr);
    @(posedge pclk);
    apb(1'b0, `MSP_OFF_SPIDATA, 32'h0000_0000);
    chk(rdat, 32'h0000_8E21);
    msp_host_model_inst.abort_frame();
    chk(miso_oe, 32'h0000_0000);
    msp_host_model_inst.xfer(16'h0E00, sr);
    chk(sr, 32'h0000_0021);
    msp_host_model_inst.xfer(16'h4300, sr);
    chk(sr, 32'h0000_0008);
    @(posedge pclk);
    apb(1'b1, `MSP_OFF_MOTCFG, 32'h0000_0001);
    motion_seen <= 1'b1;
    motion_dx <= 8'h05;
    motion_dy <= 8'hFA;
    @(posedge pclk);
    motion_seen <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(motion_pin, 32'h0000_0001);
    chk(power_mode, 32'h0000_0001);
    apb(1'b0, `MSP_OFF_STATUS, 32'h0000_0000);
    chk(rdat, 32'h0000_0003);
    apb(1'b0, `MSP_OFF_DELTA, 32'h0000_0000);
    chk(rdat, 32'h0000_FA05);
    repeat (10) @(posedge pclk);
    chk(motion_pin, 32'h0000_0000);
    apb(1'b0, `MSP_OFF_STATUS, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    apb(1'b1, `MSP_OFF_MOTCFG, 32'h0000_0000);
    repeat (10) @(posedge pclk);
    chk(motion_pin, 32'h0000_0001);
    motion_seen <= 1'b1;
    motion_dx <= 8'h03;
    motion_dy <= 8'h04;
    @(posedge pclk);
    motion_seen <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(motion_pin, 32'h0000_0000);
    msp_host_model_inst.xfer(16'h0300, sr);
    chk(sr, 32'h0000_0003);
    chk(motion_pin, 32'h0000_0000);
    msp_host_model_inst.xfer(16'h0400, sr);
    chk(sr, 32'h0000_0004);
    chk(motion_pin, 32'h0000_0001);
    @(posedge pclk);
    apb(1'b0, `MSP_OFF_STATUS, 32'h0000_0000);
    chk(rdat, 32'h0000_0002);
    wrap_up();
  end
endmodule
bind msp_sensor_port msp_sensor_port_sva msp_sensor_port_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .port_select_n(port_select_n), .sclk_in(sclk_in),
  .miso_o(miso_o), .miso_oe(miso_oe), .power_mode(power_mode));
